// [dds_serial_defs.vh]
// Register addresses, field positions, reset values and timing for the serial register bank
`ifndef DDS_SERIAL_DEFS_VH
`define DDS_SERIAL_DEFS_VH
`define ADDR_CONTROL_FUNCTION_ONE 5'h00
`define ADDR_CONTROL_FUNCTION_TWO 5'h01
`define ADDR_AMPLITUDE_SCALE_FACTOR 5'h02
`define ADDR_AMPLITUDE_RAMP_RATE 5'h03
`define ADDR_FREQUENCY_TUNING_WORD 5'h04
`define ADDR_PHASE_OFFSET_WORD 5'h05
`define RESET_CONTROL_FUNCTION_ONE 32'h00000000
`define RESET_CONTROL_FUNCTION_TWO 24'h000000
`define RESET_AMPLITUDE_SCALE_FACTOR 16'h0000
`define RESET_AMPLITUDE_RAMP_RATE 8'h00
`define RESET_FREQUENCY_TUNING_WORD 32'h00000000
`define RESET_PHASE_OFFSET_WORD 16'h0000
`define BIT_LSB_FIRST 8
`define BIT_SDIO_INPUT_ONLY 9
`define BIT_CLEAR_PHASE_ACCUM 10
`define MULT_MSB 7
`define MULT_LSB 3
`define BIT_VCO_GAIN 2
`define PUMP_MSB 1
`define PUMP_LSB 0
`define MULT_MIN 5'h04
`define MULT_MAX 5'h14
`define LOCK_TIME_US 1000
`define LOCK_CYCLES ((`LOCK_TIME_US * 100) / 1)
`endif

// [pin_sync.v]
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
  input wire clk,
  input wire reset,
  input wire resetValue,
  input wire pinIn,
  output reg pinOut
);
  reg stage1;
  reg stage2;
  reg stage3;
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= resetValue;
      stage2 <= resetValue;
      stage3 <= resetValue;
      pinOut <= resetValue;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        pinOut <= stage3;
      end
    end
  end
endmodule
`default_nettype wire

// [dds_serial_control_registers.v]
// Serially programmed configuration register bank of a direct digital synthesizer
//
// Notes on behaviour
// R1: Transfers run most significant bit first, or least significant bit first when that bit is set.
// R2: Read data leaves on the shared data pin in two-wire mode or on the separate output pin in three-wire mode.
// R3: Every register can be written and read back over the serial port.
// R4: The address in the instruction byte picks one of six registers at 0x00 through 0x05.
// R5: A multiplier field of 0 to 3 bypasses the multiplier and 4 to 20 multiplies by that value.
// R6: The low byte of control function two also holds the oscillator gain bit and a two-bit pump current field.
// R7: The ramp rate register is one eight-bit step interval value.
// R8: Chip select and port resync are optional host pins that frame or restart a transfer.
// R9: After reset every register reads as zero.
// R10: A multiplier value outside 4 to 20 bypasses the multiplier and powers it down.
// R11: The host waits about one millisecond after a multiplier change before trusting the system clock.
// R12: Accumulator clear is held active after reset until the first update strobe loads the working copy.
`timescale 1ns/10ps
`default_nettype none
`include "dds_serial_defs.vh"
module dds_serial_control_registers
#(
  parameter LOCK_CYCLES = `LOCK_CYCLES
)
(
  input wire clk,
  input wire reset,
  input wire serialClockPin,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOutEn,
  output reg serial_data_out_pin,
  input wire chip_select_low_pin,
  input wire port_resync_pin,
  input wire ioUpdatePin,
  output reg [31:0] controlOne,
  output reg [23:0] controlTwo,
  output reg [15:0] amplitudeScale,
  output reg [7:0] rampRate,
  output reg [31:0] tuningWord,
  output reg [15:0] phaseOffset,
  output reg [4:0] multiplierValue,
  output reg multiplierEnable,
  output reg vcoGain,
  output reg [1:0] pumpCurrent,
  output reg clearPhaseAccum,
  output reg multiplierLocked
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire sclkS;
  wire sdiS;
  wire csS;
  wire resyncS;
  wire updS;
  pin_sync uSclk (.clk(clk), .reset(reset), .resetValue(1'b0), .pinIn(serialClockPin), .pinOut(sclkS));
  pin_sync uSdi (.clk(clk), .reset(reset), .resetValue(1'b0), .pinIn(serialDataIn), .pinOut(sdiS));
  pin_sync uCs (.clk(clk), .reset(reset), .resetValue(1'b0), .pinIn(chip_select_low_pin), .pinOut(csS));
  pin_sync uRs (.clk(clk), .reset(reset), .resetValue(1'b0), .pinIn(port_resync_pin), .pinOut(resyncS));
  pin_sync uUpd (.clk(clk), .reset(reset), .resetValue(1'b0), .pinIn(ioUpdatePin), .pinOut(updS));

  function [5:0] regBits;
    input [4:0] a;
    begin
      case (a)
        `ADDR_CONTROL_FUNCTION_ONE: regBits = 6'd32;
        `ADDR_CONTROL_FUNCTION_TWO: regBits = 6'd24;
        `ADDR_AMPLITUDE_SCALE_FACTOR: regBits = 6'd16;
        `ADDR_AMPLITUDE_RAMP_RATE: regBits = 6'd8;
        `ADDR_FREQUENCY_TUNING_WORD: regBits = 6'd32;
        `ADDR_PHASE_OFFSET_WORD: regBits = 6'd16;
        default: regBits = 6'd8;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Buffered registers and serial engine
  // ----------------------------------------------------------------
  localparam ST_INSTR = 2'd0;
  localparam ST_DATA = 2'd1;
  reg [1:0] state_q;
  reg sclkPrev_q;
  reg updPrev_q;
  reg [5:0] bitCnt_q;
  reg [7:0] instr_q;
  reg [31:0] shift_q;
  reg [31:0] buf1_q;
  reg [23:0] buf2_q;
  reg [15:0] bufAsf_q;
  reg [7:0] bufArr_q;
  reg [31:0] bufFtw_q;
  reg [15:0] bufPow_q;
  reg [4:0] multPrev_q;
  reg [31:0] lockCnt_q;
  reg [31:0] readWord;
  reg [5:0] dataBits;
  reg [5:0] outIdx;
  wire sclkRise = sclkS & ~sclkPrev_q;
  wire sclkFall = ~sclkS & sclkPrev_q;
  wire abort = csS | resyncS; // R8
  // Port format takes effect on the update strobe, like every other setting
  wire lsbFirst = controlOne[`BIT_LSB_FIRST];
  wire threeWire = controlOne[`BIT_SDIO_INPUT_ONLY];
  wire [4:0] addr = instr_q[4:0];
  wire isRead = instr_q[7];
  wire [7:0] instrNext = lsbFirst ? {sdiS, instr_q[7:1]} : {instr_q[6:0], sdiS}; // R1
  wire [4:0] multField = controlTwo[`MULT_MSB:`MULT_LSB];

  always @*
  begin
    dataBits = regBits(addr);
    case (addr)
      `ADDR_CONTROL_FUNCTION_ONE: readWord = buf1_q; // R3
      `ADDR_CONTROL_FUNCTION_TWO: readWord = {8'h00, buf2_q};
      `ADDR_AMPLITUDE_SCALE_FACTOR: readWord = {16'h0000, bufAsf_q};
      `ADDR_AMPLITUDE_RAMP_RATE: readWord = {24'h000000, bufArr_q};
      `ADDR_FREQUENCY_TUNING_WORD: readWord = bufFtw_q;
      `ADDR_PHASE_OFFSET_WORD: readWord = {16'h0000, bufPow_q};
      default: readWord = 32'h00000000;
    endcase
    outIdx = lsbFirst ? bitCnt_q : dataBits - 6'd1 - bitCnt_q; // R1
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_INSTR;
      sclkPrev_q <= 1'b0;
      updPrev_q <= 1'b0;
      bitCnt_q <= 6'd0;
      instr_q <= 8'h00;
      shift_q <= 32'h00000000;
      buf1_q <= `RESET_CONTROL_FUNCTION_ONE; // R9
      buf2_q <= `RESET_CONTROL_FUNCTION_TWO;
      bufAsf_q <= `RESET_AMPLITUDE_SCALE_FACTOR;
      bufArr_q <= `RESET_AMPLITUDE_RAMP_RATE;
      bufFtw_q <= `RESET_FREQUENCY_TUNING_WORD;
      bufPow_q <= `RESET_PHASE_OFFSET_WORD;
      serialDataOut <= 1'b0;
      serialDataOutEn <= 1'b0;
      serial_data_out_pin <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclkS;
      if (abort)
      begin
        state_q <= ST_INSTR;
        bitCnt_q <= 6'd0;
        serialDataOutEn <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_INSTR:
          begin
            if (sclkRise)
            begin
              instr_q <= instrNext;
              shift_q <= 32'h00000000;
              if (bitCnt_q == 6'd7)
              begin
                bitCnt_q <= 6'd0;
                state_q <= ST_DATA;
              end
              else
              begin
                bitCnt_q <= bitCnt_q + 6'd1;
              end
            end
          end
          ST_DATA:
          begin
            if (isRead && sclkFall)
            begin
              serialDataOut <= readWord[outIdx[4:0]];
              serial_data_out_pin <= readWord[outIdx[4:0]];
              serialDataOutEn <= ~threeWire; // R2
            end
            if (sclkRise)
            begin
              if (!isRead)
              begin
                shift_q[outIdx[4:0]] <= sdiS;
              end
              if (bitCnt_q == dataBits - 6'd1)
              begin
                bitCnt_q <= 6'd0;
                state_q <= ST_INSTR;
                serialDataOutEn <= 1'b0;
                if (!isRead)
                begin
                  case (addr) // R4
                    `ADDR_CONTROL_FUNCTION_ONE: buf1_q <= shift_q;
                    `ADDR_CONTROL_FUNCTION_TWO: buf2_q <= shift_q[23:0];
                    `ADDR_AMPLITUDE_SCALE_FACTOR: bufAsf_q <= shift_q[15:0];
                    `ADDR_AMPLITUDE_RAMP_RATE: bufArr_q <= shift_q[7:0]; // R7
                    `ADDR_FREQUENCY_TUNING_WORD: bufFtw_q <= shift_q;
                    `ADDR_PHASE_OFFSET_WORD: bufPow_q <= shift_q[15:0];
                    default: bufArr_q <= bufArr_q;
                  endcase
                end
              end
              else
              begin
                bitCnt_q <= bitCnt_q + 6'd1;
              end
            end
          end
          default: state_q <= ST_INSTR;
        endcase
      end
      // Last bit may land in the same cycle as commit; merge it in
      if (!abort && state_q == ST_DATA && sclkRise && !isRead && bitCnt_q == dataBits - 6'd1)
      begin
        case (addr)
          `ADDR_CONTROL_FUNCTION_ONE: buf1_q[outIdx[4:0]] <= sdiS;
          `ADDR_CONTROL_FUNCTION_TWO: buf2_q[outIdx[4:0]] <= sdiS;
          `ADDR_AMPLITUDE_SCALE_FACTOR: bufAsf_q[outIdx[3:0]] <= sdiS;
          `ADDR_AMPLITUDE_RAMP_RATE: bufArr_q[outIdx[2:0]] <= sdiS;
          `ADDR_FREQUENCY_TUNING_WORD: bufFtw_q[outIdx[4:0]] <= sdiS;
          `ADDR_PHASE_OFFSET_WORD: bufPow_q[outIdx[3:0]] <= sdiS;
          default: bufArr_q <= bufArr_q;
        endcase
      end
      updPrev_q <= updS;
    end
  end

  // ----------------------------------------------------------------
  // Active registers loaded on the update strobe
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      controlOne <= `RESET_CONTROL_FUNCTION_ONE;
      controlTwo <= `RESET_CONTROL_FUNCTION_TWO;
      amplitudeScale <= `RESET_AMPLITUDE_SCALE_FACTOR;
      rampRate <= `RESET_AMPLITUDE_RAMP_RATE;
      tuningWord <= `RESET_FREQUENCY_TUNING_WORD;
      phaseOffset <= `RESET_PHASE_OFFSET_WORD;
      clearPhaseAccum <= 1'b1; // R12
      multiplierValue <= 5'h00;
      multiplierEnable <= 1'b0;
      vcoGain <= 1'b0;
      pumpCurrent <= 2'b00;
      multPrev_q <= 5'h00;
      lockCnt_q <= 32'h00000000;
      multiplierLocked <= 1'b0;
    end
    else
    begin
      if (updS && !updPrev_q)
      begin
        controlOne <= buf1_q;
        controlTwo <= buf2_q;
        amplitudeScale <= bufAsf_q;
        rampRate <= bufArr_q;
        tuningWord <= bufFtw_q;
        phaseOffset <= bufPow_q;
        clearPhaseAccum <= buf1_q[`BIT_CLEAR_PHASE_ACCUM]; // R12
      end
      // Bypassed multiplier is powered down, so its value is forced to zero
      multiplierEnable <= (multField >= `MULT_MIN) && (multField <= `MULT_MAX); // R5 R10
      multiplierValue <= ((multField >= `MULT_MIN) && (multField <= `MULT_MAX)) ? multField : 5'h00; // R5
      vcoGain <= controlTwo[`BIT_VCO_GAIN]; // R6
      pumpCurrent <= controlTwo[`PUMP_MSB:`PUMP_LSB]; // R6
      multPrev_q <= multField;
      // Lock status is only a hint for the host's settling wait
      if (multField != multPrev_q)
      begin
        lockCnt_q <= 32'h00000000;
        multiplierLocked <= 1'b0;
      end
      else if (lockCnt_q >= LOCK_CYCLES - 1)
      begin
        multiplierLocked <= 1'b1; // R11
      end
      else
      begin
        lockCnt_q <= lockCnt_q + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// [dds_regs_monitor.sv]
// Concurrent checks on the outputs of the serial register bank
`timescale 1ns/10ps
`default_nettype none
module dds_regs_monitor
#(
  parameter LOCK_CYCLES = 20
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic serialDataOutEn,
  input wire logic ioUpdatePin,
  input wire logic [31:0] controlOne,
  input wire logic [23:0] controlTwo,
  input wire logic [4:0] multiplierValue,
  input wire logic multiplierEnable,
  input wire logic vcoGain,
  input wire logic [1:0] pumpCurrent,
  input wire logic clearPhaseAccum,
  input wire logic multiplierLocked
);
  wire logic [4:0] mult = controlTwo[7:3];
  wire logic inRange = mult >= 5'h04 && mult <= 5'h14;
  int settle;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Counts from the last move of the multiplier field, so lock time is judged from there
  always @(posedge clk)
    settle <= (reset || mult != $past(mult)) ? 0 : settle + 1;
  a_mult_range: assert property ($stable(controlTwo) [*2] |-> multiplierEnable == inRange) else $error("enable");
  a_bypass_value: assert property ($stable(controlTwo) [*2] |-> multiplierValue == (inRange ? mult : 5'h00))
    else $error("mult value");
  a_pll_fields: assert property ($stable(controlTwo) [*2] |-> {vcoGain, pumpCurrent} == controlTwo[2:0])
    else $error("pll fields");
  a_three_wire: assert property (controlOne[9] [*3] |-> !serialDataOutEn) else $error("shared pin driven");
  a_hold_active: assert property ((!ioUpdatePin) [*8] |=> $stable(controlOne) && $stable(controlTwo))
    else $error("active changed");
  a_clear_hold: assert property ((clearPhaseAccum && !ioUpdatePin) [*8] |=> clearPhaseAccum) else $error("clear");
  a_clear_bit: assert property ($stable(controlOne) [*2] ##0 controlOne[10] |-> clearPhaseAccum)
    else $error("clear bit");
  a_lock_time: assert property ($rose(multiplierLocked) |-> settle >= LOCK_CYCLES - 3) else $error("early lock");
endmodule
bind dds_serial_control_registers dds_regs_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) mon (
  .clk(clk),
  .reset(reset),
  .serialDataOutEn(serialDataOutEn),
  .ioUpdatePin(ioUpdatePin),
  .controlOne(controlOne),
  .controlTwo(controlTwo),
  .multiplierValue(multiplierValue),
  .multiplierEnable(multiplierEnable),
  .vcoGain(vcoGain),
  .pumpCurrent(pumpCurrent),
  .clearPhaseAccum(clearPhaseAccum),
  .multiplierLocked(multiplierLocked)
);
`default_nettype wire

// [serial_host_model.sv]
// Host model of the serial port: framed transfers in either bit order and wiring
`timescale 1ns/10ps
`default_nettype none
module serial_host_model
(
  input wire logic clk,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  input wire logic serial_data_out_pin,
  output logic serialClockPin,
  output wire logic serialDataIn
);
  logic hostBit = 1'b0;
  logic threeWire = 1'b0;
  logic lsbFirst = 1'b0;
  assign serialDataIn = serialDataOutEn ? serialDataOut : hostBit;
  initial
    serialClockPin = 1'b0;
  // Instruction byte, then n data bits; the clock stands low between frames
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] wr, input int n,
                      output logic [31:0] got);
    logic [7:0] ins;
    int i;
    int j;
    ins = {rd, 2'b00, a};
    got = 32'h0;
    for (i = 0; i < n + 8; i++)
    begin
      j = i < 8 ? (lsbFirst ? i : 7 - i) : (lsbFirst ? i - 8 : n + 7 - i);
      serialClockPin = 1'b0;
      if (i < 8 || !rd)
        hostBit = i < 8 ? ins[j] : wr[j];
      else
        hostBit = ~hostBit; // A released pin must not hold the last bit
      repeat (8) @(negedge clk);
      if (i >= 8)
        got[j] = threeWire ? serial_data_out_pin : serialDataIn;
      serialClockPin = 1'b1;
      repeat (8) @(negedge clk);
    end
    serialClockPin = 1'b0;
    repeat (16) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the serial register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic chip_select_low_pin = 1'b0;
  logic port_resync_pin = 1'b0;
  logic ioUpdatePin = 1'b0;
  wire logic serialClockPin, serialDataIn, serialDataOut, serialDataOutEn, serial_data_out_pin;
  wire logic multiplierEnable, vcoGain, clearPhaseAccum, multiplierLocked;
  wire logic [31:0] controlOne, tuningWord;
  wire logic [23:0] controlTwo;
  wire logic [15:0] amplitudeScale, phaseOffset;
  wire logic [7:0] rampRate;
  wire logic [4:0] multiplierValue;
  wire logic [1:0] pumpCurrent;
  int widths [6] = '{32, 24, 16, 8, 32, 16};
  logic [31:0] vals [6] = '{32'h12340056, 32'ha6, 32'h3abc, 32'h5a, 32'hdeadbeef, 32'h2345};
  int mults [4] = '{3, 21, 4, 20};
  int fails = 0;
  int check_count = 0;
  int i;
  logic en;
  logic [31:0] rd;
  always #5 clk = ~clk;
  serial_host_model host (.*);
  dds_serial_control_registers #(.LOCK_CYCLES(20)) DUT (.*);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input int a, input logic [31:0] v);
    host.xfer(1'b0, a[4:0], v, widths[a], rd);
  endtask
  task automatic rdchk(input string what, input int a, input logic [31:0] exp);
    host.xfer(1'b1, a[4:0], 32'h0, widths[a], rd);
    check(what, exp, rd);
  endtask
  // Two-cycle strobe, then room for the synchronised copy to land
  task automatic update;
    ioUpdatePin = 1'b1;
    repeat (2) @(negedge clk);
    ioUpdatePin = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  function automatic logic [31:0] act(input int a);
    case (a)
      0: return controlOne;
      1: return 32'(controlTwo);
      2: return 32'(amplitudeScale);
      3: return 32'(rampRate);
      4: return tuningWord;
      default: return 32'(phaseOffset);
    endcase
  endfunction
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check("clearAtReset", 32'h1, 32'(clearPhaseAccum));
    for (i = 0; i < 6; i++)
    begin
      rdchk("resetRead", i, 32'h0);
      check("resetActive", 32'h0, act(i));
      wr(i, vals[i]);
      check("beforeUpdate", 32'h0, act(i));
    end
    update;
    check("clearAfterUpdate", 32'h0, 32'(clearPhaseAccum));
    check("pllFields", 32'h6, 32'({vcoGain, pumpCurrent}));
    for (i = 0; i < 6; i++)
    begin
      rdchk("readBack", i, vals[i]);
      check("active", vals[i], act(i));
    end
    host.xfer(1'b1, 5'h07, 32'h0, 8, rd);
    check("unmapped", 32'h0, rd);
    foreach (mults[k])
    begin
      wr(1, {24'h0, mults[k][4:0], 3'b110});
      update;
      en = mults[k] >= 4 && mults[k] <= 20;
      check("multEnable", 32'(en), 32'(multiplierEnable));
      check("multValue", 32'(en ? mults[k] : 0), 32'(multiplierValue));
    end
    check("notLocked", 32'h0, 32'(multiplierLocked));
    for (i = 0; i < 100 && multiplierLocked !== 1'b1; i++)
      @(negedge clk);
    check("locked", 32'h1, 32'(multiplierLocked));
    wr(0, 32'h200);
    update;
    host.threeWire = 1'b1;
    rdchk("threeWire", 4, 32'hdeadbeef);
    wr(0, 32'h300);
    update;
    host.lsbFirst = 1'b1;
    rdchk("lsbRead", 4, 32'hdeadbeef);
    for (i = 0; i < 2; i++)
    begin
      host.xfer(1'b0, 5'h04, 32'h0, 12, rd);
      {port_resync_pin, chip_select_low_pin} = i ? 2'b10 : 2'b01;
      repeat (10) @(negedge clk);
      {port_resync_pin, chip_select_low_pin} = 2'b00;
      repeat (4) @(negedge clk);
      wr(5, 32'hf0 + i);
      update;
      check("abortKept", 32'hdeadbeef, tuningWord);
      check("afterAbort", 32'hf0 + i, 32'(phaseOffset));
    end
    wr(0, 32'h700);
    update;
    check("clearBitSet", 32'h1, 32'(clearPhaseAccum));
    rdchk("cfgRead", 0, 32'h700);
    finish_test;
  end
endmodule
`default_nettype wire
